// [hdl/touch_reset_regs.svh]
// Timing counts and field positions of the touch controller reset qualifier.
// Assumes the core clock runs at the rate given by RSTQ_CLK_MHZ.
`ifndef TOUCH_RESET_REGS_SVH
`define TOUCH_RESET_REGS_SVH

// ==================================================================
// Clock rate
`define RSTQ_CLK_MHZ 50

// ==================================================================
// Reset pulse figures in nanoseconds
`define RSTQ_VALID_MIN_NS 10000
`define RSTQ_REJECT_MAX_NS 5000
`define RSTQ_QUAL_NS 7500
`define RSTQ_SPIKE_NS 20

// Derived cycle counts; the threshold sits mid band so drift moves it neither way.
`define RSTQ_QUAL_CYCLES ((`RSTQ_QUAL_NS * `RSTQ_CLK_MHZ) / 1000)
`define RSTQ_REJECT_CYCLES ((`RSTQ_REJECT_MAX_NS * `RSTQ_CLK_MHZ) / 1000)
`define RSTQ_SPIKE_CYCLES (((`RSTQ_SPIKE_NS * `RSTQ_CLK_MHZ) + 999) / 1000)

// ==================================================================
// Least supply off time in milliseconds before a clean power-on
`define RSTQ_OFF_MIN_MS 200
`define RSTQ_OFF_CYCLES (`RSTQ_OFF_MIN_MS * `RSTQ_CLK_MHZ * 1000)

// ==================================================================
// Width of the internal reset pulse after any reset source
`define RSTQ_PULSE_CYCLES 4

// ==================================================================
// Control byte one fields
`define RSTQ_SOFT_RESET_BIT 1

`endif

// [hdl/touch_reset_pkg.sv]
// Types shared by the touch controller reset qualifier.
// Assumes nothing beyond a SystemVerilog compiler.
package touch_reset_pkg;

   // ===============================================================
   // Sequencer states
   typedef enum logic [1:0] {
      ST_POR_HOLD,
      ST_RESET_PULSE,
      ST_RUN,
      ST_LOCKED
   } seq_state_t;

   // ===============================================================
   // Record of the last reset source
   typedef struct packed {
      logic powerOn;
      logic hardware;
      logic software;
   } reset_cause_t;

   // ===============================================================
   // Conversion kinds and their measurement groups
   typedef enum logic [2:0] {
      CONV_X_PLATE_A,
      CONV_X_PLATE_B,
      CONV_X_CURRENT,
      CONV_Y_PLATE_A,
      CONV_Y_PLATE_B,
      CONV_Y_CURRENT,
      CONV_PRESSURE_A,
      CONV_PRESSURE_B
   } conv_kind_t;

   typedef enum logic [1:0] {
      GRP_X_TRIPLET,
      GRP_Y_TRIPLET,
      GRP_Z_PAIR
   } conv_group_t;

   typedef struct packed {
      conv_group_t group;
      logic lastOfGroup;
   } conv_info_t;

endpackage : touch_reset_pkg

// [hdl/pin_sync.sv]
// Three stage synchroniser for one asynchronous pin.
// Assumes the pin may change at any time relative to sys_clk.
`timescale 1ns/1ps
`default_nettype none

module pin_sync #(
   parameter logic RESET_LEVEL = 1'b1
) (
   // Clock and reset
   input wire logic sys_clk,
   input wire logic rst,
   // Pin and filtered level
   input wire logic pinIn,
   output logic levelOut
);

   // ===============================================================
   // Stages
   logic [2:0] stage_r;
   logic [2:0] stage_nxt;
   logic level_r;
   logic level_nxt;

   // The level moves only when stages two and three agree, so a single
   // sample glitch never reaches the output.
   always_comb begin
      stage_nxt = {stage_r[1:0], pinIn};
      level_nxt = (stage_r[2] == stage_r[1]) ? stage_r[2] : level_r;
   end

   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         stage_r <= {3{RESET_LEVEL}};
         level_r <= RESET_LEVEL;
      end else begin
         stage_r <= stage_nxt;
         level_r <= level_nxt;
      end
   end

   assign levelOut = level_r;

endmodule : pin_sync

`default_nettype wire

// [hdl/touch_ctrl_reset_qualifier.sv]
// Reset qualifier and sequencer of a resistive touch controller.
// Assumes supply monitors and pins arrive asynchronously; the control byte
// strobe comes from serial logic on sys_clk.
`timescale 1ns/1ps
`default_nettype none
`include "touch_reset_regs.svh"

module touch_ctrl_reset_qualifier
   import touch_reset_pkg::*;
#(
   parameter int QUAL_CYCLES = `RSTQ_QUAL_CYCLES,
   parameter int OFF_CYCLES = `RSTQ_OFF_CYCLES
) (
   // Clock and reset
   input wire logic sys_clk,
   input wire logic rst,
   // Pins from the host side
   input wire logic resetPinN,
   input wire logic addrSelectBit0,
   input wire logic addrSelectBit1,
   // Supply monitors, high while the rail is above its threshold
   input wire logic senseSupplyOk,
   input wire logic ioSupplyOk,
   // Control byte one from the serial interface
   input wire logic ctrlByte1Wr,
   input wire logic [7:0] ctrlByte1,
   // Interrupt sources from the converter core
   input wire logic penIrqSelect,
   input wire logic dataAvail,
   input wire logic penTouchIrq,
   // Conversion step lookup
   input wire conv_kind_t convKind,
   output conv_info_t convInfo,
   // Results
   output logic coreReset,
   output reset_cause_t resetCause,
   output logic lockedUp,
   output logic [1:0] i2cAddrLow,
   output logic dataReadyPenIrqN
);

   // ===============================================================
   // Pin synchronisers
   logic pinHigh;
   logic senseOk;
   logic ioOk;
   logic addr0;
   logic addr1;

   // Two agreeing samples lie 20 ns apart, so a pulse must outlast any 20 ns spike to pass.
   pin_sync #(.RESET_LEVEL(1'b1)) u_sync_reset (
      .sys_clk(sys_clk), .rst(rst), .pinIn(resetPinN), .levelOut(pinHigh));
   pin_sync #(.RESET_LEVEL(1'b0)) u_sync_sense (
      .sys_clk(sys_clk), .rst(rst), .pinIn(senseSupplyOk), .levelOut(senseOk));
   pin_sync #(.RESET_LEVEL(1'b0)) u_sync_io (
      .sys_clk(sys_clk), .rst(rst), .pinIn(ioSupplyOk), .levelOut(ioOk));
   pin_sync #(.RESET_LEVEL(1'b0)) u_sync_a0 (
      .sys_clk(sys_clk), .rst(rst), .pinIn(addrSelectBit0), .levelOut(addr0));
   pin_sync #(.RESET_LEVEL(1'b0)) u_sync_a1 (
      .sys_clk(sys_clk), .rst(rst), .pinIn(addrSelectBit1), .levelOut(addr1));

   // ===============================================================
   // Hardware reset pulse qualification
   localparam int CNT_W = $clog2(QUAL_CYCLES + 1);
   localparam logic [CNT_W-1:0] QUAL_LAST = CNT_W'(QUAL_CYCLES - 1);

   logic [CNT_W-1:0] lowCnt_r;
   logic [CNT_W-1:0] lowCnt_nxt;
   logic hwQual;
   logic pinLow;
   logic railOk;

   assign pinLow = !pinHigh;
   assign railOk = senseOk || ioOk;

   always_comb begin
      lowCnt_nxt = '0;
      hwQual = 1'b0;
      if (pinLow && railOk) begin
         if (lowCnt_r != CNT_W'(QUAL_CYCLES)) begin
            lowCnt_nxt = lowCnt_r + CNT_W'(1);
         end else begin
            lowCnt_nxt = lowCnt_r;
         end
         hwQual = (lowCnt_r == QUAL_LAST);
      end
   end

   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         lowCnt_r <= '0;
      end else begin
         lowCnt_r <= lowCnt_nxt;
      end
   end

   // ===============================================================
   // Supply off time measurement
   localparam int OFF_W = $clog2(OFF_CYCLES + 1);

   logic [OFF_W-1:0] offCnt_r;
   logic [OFF_W-1:0] offCnt_nxt;
   logic offLong;

   // The counter starts saturated: leaving system reset counts as a clean power-on.
   always_comb begin
      offCnt_nxt = offCnt_r;
      if (senseOk) begin
         offCnt_nxt = '0;
      end else if (offCnt_r != OFF_W'(OFF_CYCLES)) begin
         offCnt_nxt = offCnt_r + OFF_W'(1);
      end
   end

   assign offLong = (offCnt_r == OFF_W'(OFF_CYCLES));

   logic offLongSeen_r;
   logic offLongSeen_nxt;

   always_comb begin
      offLongSeen_nxt = offLongSeen_r;
      if (!senseOk && offLong) begin
         offLongSeen_nxt = 1'b1;
      end else if (senseOk) begin
         offLongSeen_nxt = 1'b0;
      end
   end

   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         offCnt_r <= OFF_W'(OFF_CYCLES);
         offLongSeen_r <= 1'b1;
      end else begin
         offCnt_r <= offCnt_nxt;
         offLongSeen_r <= offLongSeen_nxt;
      end
   end

   // ===============================================================
   // Reset sequencer
   localparam logic [2:0] PULSE_LAST = 3'(`RSTQ_PULSE_CYCLES - 1);

   seq_state_t state_r;
   seq_state_t state_nxt;
   logic [2:0] pulseCnt_r;
   logic [2:0] pulseCnt_nxt;
   reset_cause_t cause_r;
   reset_cause_t cause_nxt;
   logic softReq;

   assign softReq = ctrlByte1Wr && ctrlByte1[`RSTQ_SOFT_RESET_BIT];

   always_comb begin
      state_nxt = state_r;
      pulseCnt_nxt = '0;
      cause_nxt = cause_r;
      case (state_r)
         ST_POR_HOLD: begin
            if (senseOk) begin
               if (offLongSeen_r) begin
                  state_nxt = ST_RESET_PULSE;
                  cause_nxt = '{powerOn: 1'b1, hardware: 1'b0, software: 1'b0};
               end else begin
                  state_nxt = ST_LOCKED;
               end
            end
         end
         ST_RESET_PULSE: begin
            pulseCnt_nxt = pulseCnt_r + 3'(1);
            if (!senseOk) begin
               state_nxt = ST_POR_HOLD;
            end else if (pulseCnt_r == PULSE_LAST) begin
               state_nxt = ST_RUN;
            end
         end
         ST_RUN: begin
            if (!senseOk) begin
               state_nxt = ST_POR_HOLD;
            end else if (hwQual) begin
               state_nxt = ST_RESET_PULSE;
               cause_nxt = '{powerOn: 1'b0, hardware: 1'b1, software: 1'b0};
            end else if (softReq) begin
               state_nxt = ST_RESET_PULSE;
               cause_nxt = '{powerOn: 1'b0, hardware: 1'b0, software: 1'b1};
            end
         end
         ST_LOCKED: begin
            // Neither reset source reaches here; only a long enough power-off does.
            if (!senseOk) begin
               state_nxt = ST_POR_HOLD;
            end
         end
         default: begin
            state_nxt = ST_POR_HOLD;
         end
      endcase
   end

   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         state_r <= ST_POR_HOLD;
         pulseCnt_r <= '0;
         cause_r <= '0;
      end else begin
         state_r <= state_nxt;
         pulseCnt_r <= pulseCnt_nxt;
         cause_r <= cause_nxt;
      end
   end

   // ===============================================================
   // Outputs
   logic coreReset_r;
   logic coreReset_nxt;
   logic irqN_r;
   logic irqN_nxt;
   logic [1:0] addr_r;
   logic [1:0] addr_nxt;

   always_comb begin
      coreReset_nxt = (state_nxt != ST_RUN);
      addr_nxt = {addr1, addr0};
      // The pin idles high from the cycle after coreReset rises, so the host never sees a stale event.
      if (coreReset_r) begin
         irqN_nxt = 1'b1;
      end else begin
         irqN_nxt = penIrqSelect ? !penTouchIrq : !dataAvail;
      end
   end

   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         coreReset_r <= 1'b1;
         irqN_r <= 1'b1;
         addr_r <= 2'h0;
      end else begin
         coreReset_r <= coreReset_nxt;
         irqN_r <= irqN_nxt;
         addr_r <= addr_nxt;
      end
   end

   assign coreReset = coreReset_r;
   assign resetCause = cause_r;
   assign lockedUp = (state_r == ST_LOCKED);
   assign i2cAddrLow = addr_r;
   assign dataReadyPenIrqN = irqN_r;

   // ===============================================================
   // Conversion grouping lookup
   always_comb begin
      case (convKind)
         CONV_X_PLATE_A: convInfo = '{group: GRP_X_TRIPLET, lastOfGroup: 1'b0};
         CONV_X_PLATE_B: convInfo = '{group: GRP_X_TRIPLET, lastOfGroup: 1'b0};
         CONV_X_CURRENT: convInfo = '{group: GRP_X_TRIPLET, lastOfGroup: 1'b1};
         CONV_Y_PLATE_A: convInfo = '{group: GRP_Y_TRIPLET, lastOfGroup: 1'b0};
         CONV_Y_PLATE_B: convInfo = '{group: GRP_Y_TRIPLET, lastOfGroup: 1'b0};
         CONV_Y_CURRENT: convInfo = '{group: GRP_Y_TRIPLET, lastOfGroup: 1'b1};
         CONV_PRESSURE_A: convInfo = '{group: GRP_Z_PAIR, lastOfGroup: 1'b0};
         CONV_PRESSURE_B: convInfo = '{group: GRP_Z_PAIR, lastOfGroup: 1'b1};
         default: convInfo = '{group: GRP_Z_PAIR, lastOfGroup: 1'b1};
      endcase
   end

   // ===============================================================
   // Assertions
   default clocking cb @(posedge sys_clk);
   endclocking
   default disable iff (rst);

   a_hw_qual_width: assert property (
      hwQual |-> $past(pinLow, 300) && $past(railOk, 300))
      else $error("Hardware reset qualified on a short low pulse.");

   a_short_reject: assert property (
      (state_r == ST_RUN && senseOk && !softReq && pinLow && lowCnt_r < QUAL_LAST)
      |=> state_r == ST_RUN)
      else $error("Short reset pulse disturbed normal operation.");

   a_hw_reset_pulse: assert property (
      (state_r == ST_RUN && senseOk && hwQual) |=> coreReset_r [*4])
      else $error("Qualified reset did not hold the core in reset.");

   a_soft_reset: assert property (
      (state_r == ST_RUN && senseOk && !hwQual && softReq)
      |=> state_r == ST_RESET_PULSE && cause_r.software)
      else $error("Soft reset bit did not start a reset.");

   a_lock_sticky: assert property (
      (state_r == ST_LOCKED && senseOk) |=> state_r == ST_LOCKED && coreReset_r)
      else $error("Lock-up left without a power cycle.");

   a_por_hold: assert property (
      !senseOk |=> coreReset_r)
      else $error("Core released while the supply is low.");

   a_irq_idle: assert property (
      $past(coreReset_r) |-> dataReadyPenIrqN)
      else $error("Interrupt pin active during reset.");

   a_irq_select: assert property (
      (!coreReset_r && penIrqSelect && penTouchIrq) |=> !dataReadyPenIrqN)
      else $error("Pen interrupt not driven onto the output.");

   a_addr_follow: assert property (
      (addr0 && addr1) [*2] |-> ##1 i2cAddrLow == 2'h3)
      else $error("Address bits do not follow the select pins.");

   c_hw_reset: cover property (state_r == ST_RUN && hwQual);
   c_soft_reset: cover property (state_r == ST_RUN && softReq);
   c_lockup: cover property (state_r == ST_POR_HOLD ##1 state_r == ST_LOCKED);
   c_pen_irq: cover property (!coreReset_r && penIrqSelect && !dataReadyPenIrqN);

endmodule : touch_ctrl_reset_qualifier

`default_nettype wire

// [bench/host_model.sv]
// Host side model: reset pin, supply monitors and control byte one writes.
// Assumes sys_clk from the bench; every change except those of spike lands 1 ns after a rising edge.
`timescale 1ns/1ps
`default_nettype none

module host_model (
   // Clock
   input wire logic sys_clk,
   // Interrupt pin, sampled only
   input wire logic dataReadyPenIrqN,
   // Pins and rails driven by the host
   output logic resetPinN,
   output logic senseSupplyOk,
   output logic ioSupplyOk,
   output logic ctrlByte1Wr,
   output logic [7:0] ctrlByte1
);
   // ===============================================================
   // Idle levels
   // The interrupt pin is a plain input here, never driven or pulled.
   initial begin
      resetPinN = 1'b1;
      senseSupplyOk = 1'b1;
      ioSupplyOk = 1'b1;
      ctrlByte1Wr = 1'b0;
      ctrlByte1 = 8'h00;
   end

   task automatic tick(input int n);
      repeat (n) @(posedge sys_clk);
      #1;
   endtask : tick

   // ===============================================================
   // Reset pin
   // The caller picks widths; a valid pulse is 500 cycles or more.
   task automatic pinLow(input int n);
      resetPinN = 1'b0;
      tick(n);
      resetPinN = 1'b1;
   endtask : pinLow

   // A 20 ns spike to the given level that straddles exactly one rising edge.
   task automatic spike(input logic lvl);
      @(posedge sys_clk);
      #10 resetPinN = lvl;
      #20 resetPinN = ~lvl;
      tick(1);
   endtask : spike

   // The io rail alone can drop while the sense rail holds the part up.
   task automatic setIo(input logic lvl);
      ioSupplyOk = lvl;
   endtask : setIo

   // ===============================================================
   // Control byte one; data shows its inverse once the strobe is gone.
   task automatic softWrite(input logic [7:0] data);
      ctrlByte1 = data;
      ctrlByte1Wr = 1'b1;
      tick(1);
      ctrlByte1Wr = 1'b0;
      ctrlByte1 = ~data;
   endtask : softWrite

   // ===============================================================
   // Power cycle, optionally with the pin held low through the ramp.
   task automatic powerCycle(input int off, input logic holdPin);
      senseSupplyOk = 1'b0;
      ioSupplyOk = 1'b0;
      resetPinN = ~holdPin;
      tick(off);
      senseSupplyOk = 1'b1;
      ioSupplyOk = 1'b1;
      if (holdPin) begin
         tick(520);
         resetPinN = 1'b1;
      end
   endtask : powerCycle
endmodule : host_model

`default_nettype wire

// [bench/test_touch_ctrl_reset_qualifier.sv]
// Self-checking bench of the touch controller reset qualifier.
// Assumes the host model drives pin, rails and control byte one.
`timescale 1ns/1ps
`default_nettype none

module test_touch_ctrl_reset_qualifier
   import touch_reset_pkg::*;
;

   logic sys_clk;
   logic rst;
   logic resetPinN, addrSelectBit0, addrSelectBit1, senseSupplyOk, ioSupplyOk;
   logic ctrlByte1Wr, penIrqSelect, dataAvail, penTouchIrq;
   logic [7:0] ctrlByte1;
   conv_kind_t convKind;
   conv_info_t convInfo;
   logic coreReset, lockedUp, dataReadyPenIrqN;
   reset_cause_t resetCause;
   logic [1:0] i2cAddrLow;
   int n_errors = 0;
   int compares = 0;

   // ===============================================================
   // Design and host
   touch_ctrl_reset_qualifier #(.OFF_CYCLES(50)) dut_u (
      .sys_clk(sys_clk), .rst(rst), .resetPinN(resetPinN),
      .addrSelectBit0(addrSelectBit0), .addrSelectBit1(addrSelectBit1),
      .senseSupplyOk(senseSupplyOk), .ioSupplyOk(ioSupplyOk),
      .ctrlByte1Wr(ctrlByte1Wr), .ctrlByte1(ctrlByte1), .penIrqSelect(penIrqSelect),
      .dataAvail(dataAvail), .penTouchIrq(penTouchIrq), .convKind(convKind),
      .convInfo(convInfo), .coreReset(coreReset), .resetCause(resetCause),
      .lockedUp(lockedUp), .i2cAddrLow(i2cAddrLow), .dataReadyPenIrqN(dataReadyPenIrqN));

   host_model host_u (
      .sys_clk(sys_clk), .dataReadyPenIrqN(dataReadyPenIrqN), .resetPinN(resetPinN),
      .senseSupplyOk(senseSupplyOk), .ioSupplyOk(ioSupplyOk),
      .ctrlByte1Wr(ctrlByte1Wr), .ctrlByte1(ctrlByte1));

   initial begin
      sys_clk = 1'b0;
      forever #10 sys_clk = ~sys_clk;
   end

   // ===============================================================
   // Helpers
   task automatic tick(input int n);
      repeat (n) @(posedge sys_clk);
      #1;
   endtask : tick

   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      compares++;
      if (got !== exp) begin
         n_errors++;
         $display("unexpected at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : chk

   // Counts cycles until coreReset reads the wanted level, at most lim.
   task automatic waitCore(input logic lvl, input int lim, output int n);
      n = 0;
      while (coreReset !== lvl && n < lim) begin
         tick(1);
         n++;
      end
   endtask : waitCore

   task automatic conclude();
      $display("compares %0d n_errors %0d", compares, n_errors);
      if (n_errors == 0 && compares > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask : conclude

   // ===============================================================
   // Scenarios
   task automatic t_power_on();
      int n;
      waitCore(1'b0, 30, n);
      chk(coreReset, 1'b0);
      chk(resetCause, 8'h04);
      chk(lockedUp, 1'b0);
      $display("test power_on done");
   endtask : t_power_on

   task automatic t_soft();
      int n;
      host_u.softWrite(8'hFD);
      tick(2);
      chk(coreReset, 1'b0);
      host_u.softWrite(8'h02);
      chk(coreReset, 1'b1);
      tick(1);
      chk(dataReadyPenIrqN, 1'b1);
      waitCore(1'b0, 20, n);
      chk(n[7:0], 8'h03);
      chk(resetCause, 8'h01);
      $display("test soft done");
   endtask : t_soft

   // Two thirds of the threshold and a spike must leave the soft cause in place.
   task automatic t_reject();
      host_u.pinLow(250);
      tick(10);
      host_u.spike(1'b0);
      tick(10);
      chk(coreReset, 1'b0);
      chk(resetCause, 8'h01);
      $display("test reject done");
   endtask : t_reject

   // A high spike inside the low must not restart the count; the io rail is down.
   task automatic t_valid();
      int n;
      n = 0;
      host_u.setIo(1'b0);
      fork
         host_u.pinLow(500);
         begin
            tick(100);
            host_u.spike(1'b1);
         end
         while (coreReset !== 1'b1 && n < 600) begin
            tick(1);
            n++;
         end
      join
      host_u.setIo(1'b1);
      chk(n >= 376 && n <= 382, 1'b1);
      waitCore(1'b0, 20, n);
      chk(coreReset, 1'b0);
      chk(resetCause, 8'h02);
      $display("test valid done");
   endtask : t_valid

   task automatic t_irq();
      for (int i = 0; i < 8; i++) begin
         {penIrqSelect, penTouchIrq, dataAvail} = i[2:0];
         tick(2);
         chk(dataReadyPenIrqN, !(i[2] ? i[1] : i[0]));
      end
      $display("test irq done");
   endtask : t_irq

   task automatic t_addr();
      for (int i = 0; i < 4; i++) begin
         {addrSelectBit1, addrSelectBit0} = i[1:0];
         tick(5);
         chk(i2cAddrLow, i[1:0]);
      end
      $display("test addr done");
   endtask : t_addr

   task automatic t_conv();
      for (int k = 0; k < 8; k++) begin
         convKind = conv_kind_t'(k[2:0]);
         tick(1);
         chk(convInfo, {(k < 3) ? 2'h0 : (k < 6) ? 2'h1 : 2'h2,
            k == 2 || k == 5 || k == 7});
      end
      $display("test conv done");
   endtask : t_conv

   // A short off time locks; pin and soft resets must not clear it.
   task automatic t_lockup();
      int n;
      host_u.powerCycle(10, 1'b0);
      tick(10);
      chk(lockedUp, 1'b1);
      host_u.softWrite(8'h02);
      host_u.pinLow(500);
      tick(10);
      chk(lockedUp, 1'b1);
      chk(coreReset, 1'b1);
      host_u.powerCycle(100, 1'b1);
      waitCore(1'b0, 50, n);
      chk(lockedUp, 1'b0);
      chk(coreReset, 1'b0);
      $display("test lockup done");
   endtask : t_lockup

   // ===============================================================
   // Main sequence and watchdog
   initial begin
      rst = 1'b1;
      {addrSelectBit1, addrSelectBit0, penIrqSelect, penTouchIrq, dataAvail} = 5'h00;
      convKind = CONV_X_PLATE_A;
      repeat (16) @(posedge sys_clk);
      #1 rst = 1'b0;
      t_power_on();
      dataAvail = 1'b1;
      t_soft();
      t_reject();
      t_valid();
      t_irq();
      t_addr();
      t_conv();
      rst = 1'b1;
      tick(2);
      chk(coreReset, 1'b1);
      chk(dataReadyPenIrqN, 1'b1);
      chk(i2cAddrLow, 2'h0);
      rst = 1'b0;
      t_power_on();
      t_lockup();
      conclude();
   end

   initial begin
      repeat (20000) @(posedge sys_clk);
      n_errors++;
      conclude();
   end
endmodule : test_touch_ctrl_reset_qualifier

`default_nettype wire
